// File: rtl/timer_ch0_cc_io_select.sv
// Summary of operation
// - high control bits 7:4 select register B
// - high control bits 3:0 select register A
// - low control bits 7:4 select register D
// - low control bits 3:0 select register C
// - codes 0001/0101 drive pin low on match
// - codes 0010/0110 drive pin high on match
// - codes 0011/0111 toggle pin on match
// - code 1000 captures counter on rising pin
// - code 1001 captures counter on falling pin
// - code 1010 captures both edges; 1011 undefined
// - codes 11xx capture on channel 1 count events
// - buffer mode B disables register D function
// - buffer mode A disables register C function
// - control registers cleared by reset or standby
// - mode bit 4 pairs A/C, bit 5 pairs B/D
//
// The AXI4-Lite register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "tmr_cc_params.svh"

module timer_ch0_cc_io_select #(
    parameter int CNT_W = 16
) (
    // clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 rst,
    input  wire logic                 standby,
    // axi4-lite write address / data / response
    input  wire logic [7:0]           s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    // axi4-lite read
    input  wire logic [7:0]           s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    // timer side
    input  wire logic [CNT_W-1:0]     ch0_counter,
    input  wire logic                 channel1_count_event,
    input  wire logic [3:0]           compare_match,
    // channel pins, index 0..3 = a..d
    input  wire logic [3:0]           ch0_pin_in,
    output logic [3:0]                ch0_pin_out,
    output logic [3:0]                ch0_pin_oe,
    output logic [3:0]                capture_strobe
);
    import tmr_cc_pkg::*;

    logic [7:0]       ctrl_high_ff;
    logic [7:0]       ctrl_low_ff;
    logic [7:0]       mode_ff;
    logic [CNT_W-1:0] gr_ff [4];
    logic [3:0]       pin_prev_ff;
    logic [3:0]       pin_out_ff;
    logic [3:0]       oe_ff;
    logic [3:0]       cap_ff;
    logic [7:0]       aw_addr_ff;
    logic [31:0]      w_data_ff;
    logic [3:0]       w_strb_ff;
    logic             aw_have_ff;
    logic             w_have_ff;
    logic             bvalid_ff;
    logic [1:0]       bresp_ff;
    logic             rvalid_ff;
    logic [31:0]      rdata_ff;
    logic [1:0]       rresp_ff;

    // field selection
    // c and d lose their function while paired as buffers with a and b
    wire func_sel_t func_sel_a = ctrl_high_ff[`CC_FSEL_LO_LSB +: 4];
    wire func_sel_t func_sel_b = ctrl_high_ff[`CC_FSEL_HI_LSB +: 4];
    wire func_sel_t func_sel_c = ctrl_low_ff[`CC_FSEL_LO_LSB +: 4];
    wire func_sel_t func_sel_d = ctrl_low_ff[`CC_FSEL_HI_LSB +: 4];
    wire            buffer_mode_a = mode_ff[`CC_BUF_A_BIT];
    wire            buffer_mode_b = mode_ff[`CC_BUF_B_BIT];
    wire [3:0][3:0] sel      = {func_sel_d, func_sel_c, func_sel_b, func_sel_a};
    wire [3:0]      buffered = {buffer_mode_b, buffer_mode_a, 2'b00};

    // bus decode
    // writes to read-only words are acknowledged okay and have no effect
    wire       wr_fire    = aw_have_ff && w_have_ff && !bvalid_ff;
    wire       wr_ctrl_hi = wr_fire && aw_addr_ff == `CC_ADDR_CTRL_HIGH && w_strb_ff[0];
    wire       wr_ctrl_lo = wr_fire && aw_addr_ff == `CC_ADDR_CTRL_LOW && w_strb_ff[0];
    wire       wr_mode    = wr_fire && aw_addr_ff == `CC_ADDR_MODE && w_strb_ff[0];
    wire       wr_known   = aw_addr_ff <= `CC_ADDR_PINS && aw_addr_ff[1:0] == 2'b00;
    wire       rd_fire    = s_axi_arvalid && !rvalid_ff;
    wire [7:0] nxt_mode   = (w_data_ff[7:0] & `CC_MODE_RW_MASK) | `CC_MODE_RO_MASK;

    assign s_axi_awready = !aw_have_ff && !bvalid_ff;
    assign s_axi_wready  = !w_have_ff && !bvalid_ff;
    assign s_axi_bvalid  = bvalid_ff;
    assign s_axi_bresp   = bresp_ff;
    assign s_axi_arready = !rvalid_ff;
    assign s_axi_rvalid  = rvalid_ff;
    assign s_axi_rdata   = rdata_ff;
    assign s_axi_rresp   = rresp_ff;
    assign ch0_pin_out   = pin_out_ff;
    assign ch0_pin_oe    = oe_ff;
    assign capture_strobe = cap_ff;

    // read mux
    // data is latched as the address is taken, so a capture landing while
    // rvalid waits cannot change an answer already given
    logic [31:0] rd_mux;
    logic        rd_ok;
    always_comb begin
        rd_ok  = 1'b1;
        rd_mux = 32'h0000_0000;
        unique case (s_axi_araddr)
            `CC_ADDR_CTRL_HIGH: rd_mux = {24'h00_0000, ctrl_high_ff};
            `CC_ADDR_CTRL_LOW:  rd_mux = {24'h00_0000, ctrl_low_ff};
            `CC_ADDR_MODE:      rd_mux = {24'h00_0000, mode_ff};
            `CC_ADDR_COUNTER:   rd_mux = 32'(ch0_counter);
            `CC_ADDR_GR_A:      rd_mux = 32'(gr_ff[0]);
            `CC_ADDR_GR_B:      rd_mux = 32'(gr_ff[1]);
            `CC_ADDR_GR_C:      rd_mux = 32'(gr_ff[2]);
            `CC_ADDR_GR_D:      rd_mux = 32'(gr_ff[3]);
            `CC_ADDR_PINS:      rd_mux = {24'h00_0000, oe_ff, pin_out_ff};
            default:            rd_ok  = 1'b0;
        endcase
    end

    // control registers; standby clears them like reset
    always_ff @(posedge ref_clk) begin
        if (rst || standby) begin
            ctrl_high_ff <= `CC_CTRL_RESET;
            ctrl_low_ff  <= `CC_CTRL_RESET;
            mode_ff      <= `CC_MODE_RESET;
        end else begin
            if (wr_ctrl_hi) begin
                ctrl_high_ff <= w_data_ff[7:0];
            end
            if (wr_ctrl_lo) begin
                ctrl_low_ff <= w_data_ff[7:0];
            end
            if (wr_mode) begin
                mode_ff <= nxt_mode;
            end
        end
    end

    // write channel capture
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            aw_have_ff <= 1'b0;
            w_have_ff  <= 1'b0;
            aw_addr_ff <= 8'h00;
            w_data_ff  <= 32'h0000_0000;
            w_strb_ff  <= 4'h0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= `CC_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_ff <= 1'b1;
                aw_addr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_ff <= 1'b1;
                w_data_ff <= s_axi_wdata;
                w_strb_ff <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_have_ff <= 1'b0;
                w_have_ff  <= 1'b0;
                bvalid_ff  <= 1'b1;
                bresp_ff   <= wr_known ? `CC_RESP_OKAY : `CC_RESP_SLVERR;
            end else if (bvalid_ff && s_axi_bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    // read channel
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rvalid_ff <= 1'b0;
            rdata_ff  <= 32'h0000_0000;
            rresp_ff  <= `CC_RESP_OKAY;
        end else if (rd_fire) begin
            rvalid_ff <= 1'b1;
            rdata_ff  <= rd_mux;
            rresp_ff  <= rd_ok ? `CC_RESP_OKAY : `CC_RESP_SLVERR;
        end else if (rvalid_ff && s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    // one slice per general register
    for (genvar i = 0; i < 4; i++) begin : g_reg
        wire func_sel_t  f        = sel[i];
        wire role_t      role     = buffered[i] ? ROLE_BUFFER :
                                    f[3] ? ROLE_IN_CAPTURE : ROLE_OUT_COMPARE;
        wire match_act_t act      = match_act_t'(f[1:0]);
        wire             init_lvl = f[2];
        wire             drive    = role == ROLE_OUT_COMPARE && act != MATCH_KEEP;
        wire             rise     = ch0_pin_in[i] && !pin_prev_ff[i];
        wire             fall     = !ch0_pin_in[i] && pin_prev_ff[i];
        logic            trig;
        always_comb begin
            trig = 1'b0;
            if (role == ROLE_IN_CAPTURE) begin
                if (f[2]) begin
                    trig = channel1_count_event;
                end else begin
                    unique case (f[1:0])
                        2'b00:   trig = rise;
                        2'b01:   trig = fall;
                        2'b10:   trig = rise || fall;
                        default: trig = 1'b0;
                    endcase
                end
            end
        end
        // initial level loads while the pin is not being driven, so a fresh
        // compare setting starts from its documented level
        always_ff @(posedge ref_clk) begin
            if (rst) begin
                pin_prev_ff[i] <= 1'b0;
                pin_out_ff[i]  <= 1'b0;
                oe_ff[i]       <= 1'b0;
                cap_ff[i]      <= 1'b0;
                gr_ff[i]       <= '0;
            end else begin
                pin_prev_ff[i] <= ch0_pin_in[i];
                oe_ff[i]       <= drive;
                cap_ff[i]      <= trig;
                if (trig) begin
                    gr_ff[i] <= ch0_counter;
                end
                if (!oe_ff[i] || !drive) begin
                    pin_out_ff[i] <= init_lvl;
                end else if (compare_match[i]) begin
                    unique case (act)
                        MATCH_LOW:    pin_out_ff[i] <= 1'b0;
                        MATCH_HIGH:   pin_out_ff[i] <= 1'b1;
                        MATCH_TOGGLE: pin_out_ff[i] <= !pin_out_ff[i];
                        MATCH_KEEP:   pin_out_ff[i] <= pin_out_ff[i];
                    endcase
                end
            end
        end
    end

    // assertions
    a_rising_capture: assert property (@(posedge ref_clk) disable iff (rst)
        (func_sel_a == 4'h8 && ch0_pin_in[0] && !pin_prev_ff[0]) |=> cap_ff[0])
        else $error("rising edge missed on register a");
    a_falling_capture: assert property (@(posedge ref_clk) disable iff (rst)
        (func_sel_b == 4'h9 && ch0_pin_in[1] && !pin_prev_ff[1]) |=> !cap_ff[1])
        else $error("falling capture fired on rising edge");
    a_event_capture: assert property (@(posedge ref_clk) disable iff (rst)
        (func_sel_a[3:2] == 2'b11 && channel1_count_event) |=> cap_ff[0])
        else $error("count event capture missed");
    a_buffer_d_idle: assert property (@(posedge ref_clk) disable iff (rst)
        $past(buffer_mode_b) && buffer_mode_b |-> !oe_ff[3] && !cap_ff[3])
        else $error("register d active in buffer mode");
    a_buffer_c_idle: assert property (@(posedge ref_clk) disable iff (rst)
        $past(buffer_mode_a) && buffer_mode_a |-> !oe_ff[2] && !cap_ff[2])
        else $error("register c active in buffer mode");
    a_standby_clear: assert property (@(posedge ref_clk) disable iff (rst)
        standby |=> ctrl_high_ff == 8'h00 && ctrl_low_ff == 8'h00)
        else $error("control not cleared by standby");
    a_low_on_match: assert property (@(posedge ref_clk) disable iff (rst)
        (oe_ff[0] && func_sel_a[1:0] == 2'b01 && compare_match[0] && $stable(func_sel_a))
        |=> !pin_out_ff[0])
        else $error("pin a not low after match");
    a_toggle_match: assert property (@(posedge ref_clk) disable iff (rst)
        (oe_ff[1] && func_sel_b[1:0] == 2'b11 && compare_match[1] && $stable(func_sel_b))
        |=> pin_out_ff[1] != $past(pin_out_ff[1]))
        else $error("pin b did not toggle");
    a_disabled_off: assert property (@(posedge ref_clk) disable iff (rst)
        (func_sel_a[3] == 1'b0 && func_sel_a[1:0] == 2'b00) |=> !oe_ff[0])
        else $error("disabled compare drives pin a");

    // per-field mapping: the written byte lands in the right nibble
    a_high_field_a: assert property (@(posedge ref_clk) disable iff (rst)
        (wr_ctrl_hi && !standby) |=> func_sel_a == $past(w_data_ff[3:0]))
        else $error("high control low nibble not mapped to register a");
    a_high_field_b: assert property (@(posedge ref_clk) disable iff (rst)
        (wr_ctrl_hi && !standby) |=> func_sel_b == $past(w_data_ff[7:4]))
        else $error("high control high nibble not mapped to register b");
    a_low_field_c: assert property (@(posedge ref_clk) disable iff (rst)
        (wr_ctrl_lo && !standby) |=> func_sel_c == $past(w_data_ff[3:0]))
        else $error("low control low nibble not mapped to register c");
    a_low_field_d: assert property (@(posedge ref_clk) disable iff (rst)
        (wr_ctrl_lo && !standby) |=> func_sel_d == $past(w_data_ff[7:4]))
        else $error("low control high nibble not mapped to register d");

    // compare outputs: start level, match action and hold between matches
    a_start_low_d: assert property (@(posedge ref_clk) disable iff (rst)
        ($rose(oe_ff[3]) && !$past(func_sel_d[2])) |-> !pin_out_ff[3])
        else $error("pin d did not start low");
    a_start_high_c: assert property (@(posedge ref_clk) disable iff (rst)
        ($rose(oe_ff[2]) && $past(func_sel_c[2])) |-> pin_out_ff[2])
        else $error("pin c did not start high");
    a_high_on_match: assert property (@(posedge ref_clk) disable iff (rst)
        (oe_ff[2] && !buffer_mode_a && func_sel_c[1:0] == 2'b10 && compare_match[2]
        && $stable(func_sel_c)) |=> pin_out_ff[2])
        else $error("pin c not high after match");
    a_hold_between_b: assert property (@(posedge ref_clk) disable iff (rst)
        (oe_ff[1] && !compare_match[1] && $stable(func_sel_b))
        |=> pin_out_ff[1] == $past(pin_out_ff[1]))
        else $error("pin b moved without a match");
    a_toggle_enables_c: assert property (@(posedge ref_clk) disable iff (rst)
        (func_sel_c == 4'h3 && !buffer_mode_a) |=> oe_ff[2])
        else $error("toggle compare left pin c undriven");
    a_disabled_high_b: assert property (@(posedge ref_clk) disable iff (rst)
        (func_sel_b == 4'h4) |=> !oe_ff[1])
        else $error("disabled compare drives pin b");

    // capture side: trigger per code and the value it loads, then the mode fixed bits
    a_capture_no_drive: assert property (@(posedge ref_clk) disable iff (rst)
        func_sel_a[3] |=> !oe_ff[0])
        else $error("capture register a drives its pin");
    a_falling_capture_b: assert property (@(posedge ref_clk) disable iff (rst)
        (func_sel_b == 4'h9 && !ch0_pin_in[1] && pin_prev_ff[1]) |=> cap_ff[1])
        else $error("falling edge missed on register b");
    a_both_edges_c: assert property (@(posedge ref_clk) disable iff (rst)
        (func_sel_c == 4'hA && !buffer_mode_a && ch0_pin_in[2] != pin_prev_ff[2]) |=> cap_ff[2])
        else $error("pin edge missed on register c");
    a_undefined_d: assert property (@(posedge ref_clk) disable iff (rst)
        (func_sel_d == 4'hB) |=> !cap_ff[3])
        else $error("undefined code captured on register d");
    a_event_capture_d: assert property (@(posedge ref_clk) disable iff (rst)
        (func_sel_d[3:2] == 2'b11 && !buffer_mode_b && channel1_count_event) |=> cap_ff[3])
        else $error("count event capture missed on register d");
    a_capture_load_a: assert property (@(posedge ref_clk) disable iff (rst)
        cap_ff[0] |-> gr_ff[0] == $past(ch0_counter))
        else $error("register a did not load the counter");
    a_capture_load_d: assert property (@(posedge ref_clk) disable iff (rst)
        cap_ff[3] |-> gr_ff[3] == $past(ch0_counter))
        else $error("register d did not load the counter");
    a_mode_fixed_bits: assert property (@(posedge ref_clk) disable iff (rst)
        mode_ff[7:6] == 2'b11)
        else $error("mode register fixed bits not set");
endmodule // timer_ch0_cc_io_select

// File: rtl/tmr_cc_params.svh
`ifndef TMR_CC_PARAMS_SVH
`define TMR_CC_PARAMS_SVH
// register byte addresses
`define CC_ADDR_CTRL_HIGH  8'h00
`define CC_ADDR_CTRL_LOW   8'h04
`define CC_ADDR_MODE       8'h08
`define CC_ADDR_COUNTER    8'h0C
`define CC_ADDR_GR_A       8'h10
`define CC_ADDR_GR_B       8'h14
`define CC_ADDR_GR_C       8'h18
`define CC_ADDR_GR_D       8'h1C
`define CC_ADDR_PINS       8'h20
// field positions
`define CC_FSEL_HI_LSB     4
`define CC_FSEL_LO_LSB     0
`define CC_BUF_A_BIT       4
`define CC_BUF_B_BIT       5
// reset values and mode write masks
`define CC_CTRL_RESET      8'h00
`define CC_MODE_RESET      8'hC0
`define CC_MODE_RO_MASK    8'hC0
`define CC_MODE_RW_MASK    8'h3F
// bus answers
`define CC_RESP_OKAY       2'b00
`define CC_RESP_SLVERR     2'b10
`endif

// File: rtl/tmr_cc_pkg.sv
package tmr_cc_pkg;
    typedef enum logic [1:0] {
        ROLE_OUT_COMPARE = 2'b00,
        ROLE_IN_CAPTURE  = 2'b01,
        ROLE_BUFFER      = 2'b10
    } role_t;
    typedef enum logic [1:0] {
        MATCH_KEEP   = 2'b00,
        MATCH_LOW    = 2'b01,
        MATCH_HIGH   = 2'b10,
        MATCH_TOGGLE = 2'b11
    } match_act_t;
    typedef logic [3:0] func_sel_t;
endpackage

// File: verification/pin_partner.sv
`timescale 1ns/1ps
// far side of the four channel pins: a pin the block drives reads back its
// own level, an undriven pin follows whatever the outside world applies
module pin_partner (
    // pad side of the block
    input  wire logic [3:0] pin_out,
    input  wire logic [3:0] pin_oe,
    // outside world
    input  wire logic [3:0] ext_level,
    output logic [3:0]      pin_in
);
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule // pin_partner

// File: verification/tb_timer_ch0_cc_io_select.sv
`timescale 1ns/1ps
`include "tmr_cc_params.svh"
module tb_timer_ch0_cc_io_select;
    import tmr_cc_pkg::*;
    logic        ref_clk = 0, rst = 1, standby = 0, ev = 0;
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [7:0]  awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata, rd, seed = 32'h0000_0058;
    logic [3:0]  wstrb = 4'hf, match = '0, ext = '0, pin_in, pin_out, pin_oe, strobe;
    logic [1:0]  bresp, rresp, resp;
    logic [15:0] counter = '0;
    int          n_fail = 0, n_compared = 0, cycles = 0, k, c, lvl, nr, nf, ne;

    always #50 ref_clk = ~ref_clk;

    timer_ch0_cc_io_select i_dut (.ref_clk(ref_clk), .rst(rst), .standby(standby),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ch0_counter(counter),
        .channel1_count_event(ev), .compare_match(match), .ch0_pin_in(pin_in),
        .ch0_pin_out(pin_out), .ch0_pin_oe(pin_oe), .capture_strobe(strobe));
    pin_partner i_pins (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext), .pin_in(pin_in));

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // reference pin level after one match for a compare code
    function automatic int after_match(int code, int level);
        case (code % 4)
            1: return 0;
            2: return 1;
            3: return 1 - level;
            default: return level;
        endcase
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %0t %s: saw %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic results;
        $display("counts: %0d compared, %0d mismatched", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
        while (1) begin
            @(posedge ref_clk);
            if (awvalid && awready) awvalid <= 0;
            if (wvalid && wready) wvalid <= 0;
            if (bvalid) break;
        end
        resp = bresp;
        bready <= 0;
        @(posedge ref_clk);
    endtask
    task automatic rd_reg(input logic [7:0] a);
        araddr <= a; arvalid <= 1; rready <= 1;
        while (1) begin
            @(posedge ref_clk);
            if (arvalid && arready) arvalid <= 0;
            if (rvalid) break;
        end
        rd = rdata;
        resp = rresp;
        rready <= 0;
        @(posedge ref_clk);
    endtask
    // clearing first keeps stale pin levels from posing as edges or start levels
    task automatic select(input int ch, input logic [3:0] code);
        for (int z = 0; z < 2; z++) begin
            wr(`CC_ADDR_CTRL_HIGH, ch < 2 ? (32'(code) << (4 * ch)) * z : 0);
            wr(`CC_ADDR_CTRL_LOW, ch > 1 ? (32'(code) << (4 * (ch - 2))) * z : 0);
            repeat (3) @(posedge ref_clk);
        end
    endtask
    task automatic count(input logic [3:0] m, output int n);
        n = 0;
        repeat (5) begin
            @(negedge ref_clk);
            if ((strobe & m) !== 4'h0) n++;
        end
    endtask

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles >= 20000) begin
            n_fail++;
            $display("[ERR] %0t run did not finish in time", $time);
            results;
        end
    end

    initial begin
        repeat (12) @(posedge ref_clk);
        rst <= 0;
        @(posedge ref_clk);
        rd_reg(`CC_ADDR_CTRL_HIGH); chk(rd, 0, "high control reset");
        rd_reg(`CC_ADDR_CTRL_LOW); chk(rd, 0, "low control reset");
        rd_reg(`CC_ADDR_MODE); chk(rd, `CC_MODE_RESET, "mode reset");
        rd_reg(8'h24); chk(resp, `CC_RESP_SLVERR, "unmapped read");
        wr(8'h24, 32'h0000_00FF);
        chk(resp, `CC_RESP_SLVERR, "unmapped write");
        wstrb <= 4'he;
        wr(`CC_ADDR_CTRL_HIGH, 32'h0000_0055);
        chk(resp, `CC_RESP_OKAY, "write response without low lane");
        wstrb <= 4'hf;
        rd_reg(`CC_ADDR_CTRL_HIGH);
        chk(rd, 0, "write without low byte lane");
        $display("test reset done");
        for (k = 0; k < 4; k++) for (c = 0; c < 8; c++) begin
            select(k, 4'(c));
            @(negedge ref_clk);
            chk(pin_oe[k], (c % 4) != 0, "compare enable");
            chk(pin_oe & ~(4'b0001 << k), 0, "other pins idle");
            lvl = c / 4;
            if (c % 4 != 0) chk(pin_out[k], lvl, "start level");
            repeat (2) begin
                @(posedge ref_clk); match[k] <= 1;
                @(posedge ref_clk); match[k] <= 0;
                repeat (2) @(posedge ref_clk);
                @(negedge ref_clk);
                lvl = after_match(c, lvl);
                if (c % 4 != 0) chk(pin_out[k], lvl, "match action");
            end
        end
        $display("test compare done");
        for (k = 0; k < 4; k++) for (c = 8; c < 16; c++) begin
            counter <= 16'(xs());
            select(k, 4'(c));
            @(posedge ref_clk); ext[k] <= 1; count(4'b0001 << k, nr);
            @(posedge ref_clk); ext[k] <= 0; count(4'b0001 << k, nf);
            @(posedge ref_clk); ev <= 1;
            @(posedge ref_clk); ev <= 0; count(4'b0001 << k, ne);
            chk(nr, c == 8 || c == 10, "rising capture");
            chk(nf, c == 9 || c == 10, "falling capture");
            chk(ne, c >= 12, "count event capture");
            rd_reg(8'(`CC_ADDR_GR_A + 4 * k));
            if (c != 11) chk(rd, {16'h0000, counter}, "captured count");
        end
        $display("test capture done");
        wr(`CC_ADDR_MODE, 32'h0000_0030);
        chk(resp, `CC_RESP_OKAY, "mode write response");
        rd_reg(`CC_ADDR_MODE); chk(rd, 32'h0000_00F0, "buffer modes");
        wr(`CC_ADDR_CTRL_HIGH, 32'h0000_0077);
        wr(`CC_ADDR_CTRL_LOW, 32'h0000_0077);
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
        chk(pin_oe, 4'b0011, "buffered compare");
        wr(`CC_ADDR_CTRL_LOW, 32'h0000_0088);
        repeat (3) @(posedge ref_clk);
        ext <= 4'b1100;
        count(4'b1100, nr);
        chk(nr, 0, "buffered capture");
        ext <= 4'b0000;
        $display("test buffer done");
        wr(`CC_ADDR_CTRL_LOW, 32'h0000_0011);
        standby <= 1;
        @(posedge ref_clk);
        standby <= 0;
        rd_reg(`CC_ADDR_CTRL_LOW); chk(rd, 0, "standby clears control");
        rd_reg(`CC_ADDR_CTRL_HIGH); chk(rd, 0, "standby clears control");
        rd_reg(`CC_ADDR_MODE); chk(rd, `CC_MODE_RESET, "standby clears mode");
        $display("test standby done");
        results;
    end
endmodule // tb_timer_ch0_cc_io_select
